// ==== pll_synth_params.svh ====
// Named constants for the serial-programmed synthesizer control block.
`ifndef PLL_SYNTH_PARAMS_SVH
`define PLL_SYNTH_PARAMS_SVH

// Serial word length and the position of the routing bit.
`define WORD_BITS          19
`define ROUTE_POS          0

// Synchroniser reset contents: strobe bit high at its idle level, clock and data low.
`define SYNC_RESET         3'h4

// Reference word field layout.
`define REF_RATIO_LSB      1
`define REF_RATIO_BITS     14
`define PRESC_SEL_POS      15
`define POLARITY_POS       16
`define MON_SEL_POS        17
`define PUMP_CUR_POS       18

// Main divider word field layout.
`define SWALLOW_LSB        1
`define SWALLOW_BITS       7
`define MAIN_CNT_LSB       8
`define MAIN_CNT_BITS      11

// Reset contents of the two word latches: both ratios at their least legal value.
`define REF_WORD_RESET     19'h0_0006
`define MAIN_WORD_RESET    19'h0_0300

// Register byte offsets on the AXI4-Lite slave.
`define ADDR_BITS          4
`define OFF_REF_WORD       4'h0
`define OFF_MAIN_WORD      4'h4
`define OFF_STATUS         4'h8
`define OFF_CTRL           4'hC

// Control register layout and reset value.
`define SETTLE_BITS        16
`define CTRL_RESET         16'h0040

// Status register bit positions.
`define STAT_PSAVE_POS     0
`define STAT_LOCK_POS      1
`define STAT_SETTLE_POS    2

// AXI response codes.
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Longest pump pulse, in clock cycles, while the wake-up limiter is active.
`define PUMP_CAP_CYCLES    4'h2
`define PUMP_CNT_BITS      4

`endif

// ==== pll_synth_pkg.sv ====
// Types shared by the synthesizer control block.
`include "pll_synth_params.svh"

package pll_synth_pkg;

  // Reference word as it sits in the shift register, most significant first.
  typedef struct packed {
    logic                        pump_current_hi;
    logic                        monitor_pin_select;
    logic                        phase_polarity_bit;
    logic                        prescaler_modulus_select;
    logic [`REF_RATIO_BITS-1:0]  reference_ratio_field;
    logic                        word_route_bit;
  } ref_word_s;

  // Main divider word as it sits in the shift register.
  typedef struct packed {
    logic [`MAIN_CNT_BITS-1:0]   main_counter_field;
    logic [`SWALLOW_BITS-1:0]    swallow_count_field;
    logic                        word_route_bit;
  } main_word_s;

  // Drive of one pin: level and output enable.
  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_s;

endpackage : pll_synth_pkg

// ==== serial_word_rx.sv ====
// Three-wire serial receiver: synchronises the link and assembles words.
`timescale 1ns/1ns
`include "pll_synth_params.svh"

module serial_word_rx #(
  parameter int WORD_W = `WORD_BITS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ser_data_pin,
  input  wire logic              ser_clk_pin,
  input  wire logic              load_strobe,
  output logic                   word_valid,
  output logic [WORD_W-1:0]      word
);

  // A one-bit word could not hold a routing bit and a field.
  if (WORD_W < 2) begin : g_bad_width
    $error("serial_word_rx: WORD_W must be at least 2");
  end

  // Two-stage synchronisers for data, clock and strobe, in that bit order.
  logic [2:0]        sync1_q;        // First stage, read only by the second.
  logic [2:0]        sync2_q;        // Second stage, safe to use.
  logic              clk_prev_q;     // Last synchronised serial clock.
  logic              stb_prev_q;     // Last synchronised strobe.
  logic [WORD_W-1:0] shift_q;        // Input shift register.
  logic [WORD_W-1:0] shift_d;
  logic              valid_q;        // One-cycle pulse when a word is latched.
  logic              valid_d;
  logic [WORD_W-1:0] word_q;         // Word handed over at the strobe.
  logic [WORD_W-1:0] word_d;
  logic              clk_rise;
  logic              stb_rise;

  // Edges are found on the synchronised copies; data is delayed the same
  // amount so it still pairs with its own clock edge.
  always_comb begin
    clk_rise = sync2_q[1] & ~clk_prev_q;
    stb_rise = sync2_q[2] & ~stb_prev_q;
    shift_d  = shift_q;
    valid_d  = 1'b0;
    word_d   = word_q;
    // Bits shift in only while the strobe is low; the newest bit lands at
    // the bottom so the first bit sent ends up most significant.
    if (clk_rise && !sync2_q[2]) begin
      shift_d = {shift_q[WORD_W-2:0], sync2_q[0]};
    end
    // The strobe's rising edge hands the assembled word to the latches.
    if (stb_rise) begin
      valid_d = 1'b1;
      word_d  = shift_q;
    end
  end

  // Register stage for the synchronisers, edge history and shift register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // The strobe idles high; resetting its history low would fake a rising
      // edge just after reset and latch an empty word.
      sync1_q    <= `SYNC_RESET;
      sync2_q    <= `SYNC_RESET;
      clk_prev_q <= 1'b0;
      stb_prev_q <= 1'b1;
      shift_q    <= '0;
      valid_q    <= 1'b0;
      word_q     <= '0;
    end else begin
      sync1_q    <= {load_strobe, ser_clk_pin, ser_data_pin};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[1];
      stb_prev_q <= sync2_q[2];
      shift_q    <= shift_d;
      valid_q    <= valid_d;
      word_q     <= word_d;
    end
  end

  assign word_valid = valid_q;
  assign word       = word_q;

endmodule : serial_word_rx

// ==== pll_synth_serial_control.sv ====
// Digital control of the serial-programmed PLL synthesizer with AXI4-Lite status.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "pll_synth_params.svh"

module pll_synth_serial_control #(
  parameter int WORD_W = `WORD_BITS
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ser_data_pin,
  input  wire logic                  ser_clk_pin,
  input  wire logic                  load_strobe,
  input  wire logic                  power_save_pin,
  input  wire logic                  pump_output_enable_pin,
  input  wire logic                  ref_div_pulse,
  input  wire logic                  cmp_div_pulse,
  input  wire logic [`ADDR_BITS-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`ADDR_BITS-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output pll_synth_pkg::ref_word_s   ref_setting,
  output pll_synth_pkg::main_word_s  main_setting,
  output logic                       pump_out,
  output logic                       pump_oe,
  output logic                       phase_ref_out,
  output logic                       phase_cmp_out,
  output logic                       phase_cmp_oe,
  output logic                       monitor_out,
  output logic                       lock_detect
);

  // Field layout is fixed by the package structs; other widths cannot work.
  if (WORD_W != `WORD_BITS) begin : g_bad_width
    $error("pll_synth_serial_control: WORD_W must equal the word layout width");
  end

  // Address-decode helper, used by both the write and the read channel.
  function automatic logic addr_mapped(input logic [`ADDR_BITS-1:0] a);
    addr_mapped = (a == `OFF_REF_WORD) || (a == `OFF_MAIN_WORD) ||
                  (a == `OFF_STATUS)   || (a == `OFF_CTRL);
  endfunction : addr_mapped

  // ---------------------------------------------------------------- serial link
  logic              word_valid;     // Pulse: a word was strobed in.
  logic [WORD_W-1:0] word;           // The strobed word.

  // Receiver: synchronises the three link pins and assembles words.
  serial_word_rx #(
    .WORD_W       (WORD_W)
  ) u_rx (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ser_data_pin (ser_data_pin),
    .ser_clk_pin  (ser_clk_pin),
    .load_strobe  (load_strobe),
    .word_valid   (word_valid),
    .word         (word)
  );

  // ------------------------------------------------------------ word latches
  pll_synth_pkg::ref_word_s  ref_q;   // Reference divider and config latch.
  pll_synth_pkg::ref_word_s  ref_d;
  pll_synth_pkg::main_word_s main_q;  // Main and swallow counter latch.
  pll_synth_pkg::main_word_s main_d;

  // The routing bit is the last bit shifted, so it sits at the bottom.
  // Nothing but a strobe touches these latches; power save leaves them alone.
  always_comb begin
    ref_d  = ref_q;
    main_d = main_q;
    if (word_valid) begin
      if (word[`ROUTE_POS]) begin
        ref_d = pll_synth_pkg::ref_word_s'(word);
      end else begin
        main_d = pll_synth_pkg::main_word_s'(word);
      end
    end
  end

  // Latch registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q  <= `REF_WORD_RESET;
      main_q <= `MAIN_WORD_RESET;
    end else begin
      ref_q  <= ref_d;
      main_q <= main_d;
    end
  end

  // The counters and analog sections read the latched fields directly.
  assign ref_setting  = ref_q;
  assign main_setting = main_q;

  // -------------------------------------------------------------- pin inputs
  logic [1:0] pin1_q;   // First stage for power save and pump enable pins.
  logic [1:0] pin2_q;   // Second stage: bit 0 power save, bit 1 pump enable.
  logic       ps_prev_q;

  // Both pins come from off chip and are synchronised before use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_q    <= 2'h0;
      pin2_q    <= 2'h0;
      ps_prev_q <= 1'b0;
    end else begin
      pin1_q    <= {pump_output_enable_pin, power_save_pin};
      pin2_q    <= pin1_q;
      ps_prev_q <= pin2_q[0];
    end
  end

  logic power_saving;   // High while the device is in power-saving mode.
  logic ps_exit;        // One cycle at the release of power save.
  assign power_saving = ~pin2_q[0];
  assign ps_exit      = pin2_q[0] & ~ps_prev_q;

  // ----------------------------------------------------------- phase detector
  logic                      up_q;      // Reference edge seen first.
  logic                      up_d;
  logic                      dn_q;      // Compare edge seen first.
  logic                      dn_d;
  logic [`SETTLE_BITS-1:0]   settle_q;  // Cycles left in the wake-up window.
  logic [`SETTLE_BITS-1:0]   settle_d;
  logic [`PUMP_CNT_BITS-1:0] width_q;   // Length of the current error pulse.
  logic [`PUMP_CNT_BITS-1:0] width_d;
  logic [`SETTLE_BITS-1:0]   ctrl_q;    // Wake-up window length from software.
  logic                      lead;      // Error drives the pump high.
  logic                      lag;       // Error drives the pump low.
  logic                      cap_ok;    // Pulse is still within the limit.
  pll_synth_pkg::pin_drive_s pump_d;
  pll_synth_pkg::pin_drive_s cmp_d;
  logic                      ref_lvl_d;
  logic                      mon_d;
  logic                      lock_d;

  // A phase-frequency detector: each divided edge raises its flag, and when
  // both are up they cancel. Power save clears both so the loop wakes clean.
  always_comb begin
    up_d = (up_q | ref_div_pulse) & ~((up_q | ref_div_pulse) & (dn_q | cmp_div_pulse));
    dn_d = (dn_q | cmp_div_pulse) & ~((up_q | ref_div_pulse) & (dn_q | cmp_div_pulse));
    if (power_saving) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
    // The wake-up window starts at release and counts down to zero.
    settle_d = settle_q;
    if (ps_exit) begin
      settle_d = ctrl_q;
    end else if (settle_q != '0) begin
      settle_d = settle_q - 1'b1;
    end
    // Measure how long the present error has lasted, saturating.
    width_d = '0;
    if (up_q || dn_q) begin
      width_d = (width_q == '1) ? width_q : width_q + 1'b1;
    end
    // Polarity swaps which detector flag counts as leading. In power save no
    // error is shown, so the outputs never contradict the forced lock flag.
    lead   = (ref_q.phase_polarity_bit ? up_q : dn_q) & ~power_saving;
    lag    = (ref_q.phase_polarity_bit ? dn_q : up_q) & ~power_saving;
    // Inside the wake-up window each pump pulse is cut short, trading a
    // slower first correction for no frequency jump.
    cap_ok = (settle_q == '0) || (width_q < `PUMP_CAP_CYCLES);
    // Leading: pump high, ref output low, compare output pulled low.
    // Lagging: pump low, ref output high, compare output released.
    // Balanced: pump released, ref output low, compare output released.
    pump_d.level = lead;
    pump_d.oe    = (lead | lag) & pin2_q[1] & ~power_saving & cap_ok;
    ref_lvl_d    = lag;
    cmp_d.level  = 1'b0;
    cmp_d.oe     = lead;
    // Lock is shown while no error is pending, and forced in power save.
    lock_d = power_saving | ~(up_q | dn_q);
    // The monitor shows either lock or a divided frequency chosen by polarity.
    if (ref_q.monitor_pin_select) begin
      mon_d = ref_q.phase_polarity_bit ? ref_div_pulse : cmp_div_pulse;
    end else begin
      mon_d = lock_d;
    end
  end

  // Detector state and all pin drives are registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q          <= 1'b0;
      dn_q          <= 1'b0;
      settle_q      <= '0;
      width_q       <= '0;
      pump_out      <= 1'b0;
      pump_oe       <= 1'b0;
      phase_ref_out <= 1'b0;
      phase_cmp_out <= 1'b0;
      phase_cmp_oe  <= 1'b0;
      monitor_out   <= 1'b1;
      lock_detect   <= 1'b1;
    end else begin
      up_q          <= up_d;
      dn_q          <= dn_d;
      settle_q      <= settle_d;
      width_q       <= width_d;
      pump_out      <= pump_d.level;
      pump_oe       <= pump_d.oe;
      phase_ref_out <= ref_lvl_d;
      phase_cmp_out <= cmp_d.level;
      phase_cmp_oe  <= cmp_d.oe;
      monitor_out   <= mon_d;
      lock_detect   <= lock_d;
    end
  end

  // --------------------------------------------------------- AXI4-Lite slave
  logic                  aw_have_q;   // Write address held.
  logic                  aw_have_d;
  logic [`ADDR_BITS-1:0] aw_addr_q;
  logic [`ADDR_BITS-1:0] aw_addr_d;
  logic                  w_have_q;    // Write data held.
  logic                  w_have_d;
  logic [31:0]           w_data_q;
  logic [31:0]           w_data_d;
  logic [3:0]            w_strb_q;
  logic [3:0]            w_strb_d;
  logic                  bvalid_d;
  logic [1:0]            bresp_d;
  logic [`SETTLE_BITS-1:0] ctrl_d;
  logic                  arready_d;
  logic                  rvalid_d;
  logic [31:0]           rdata_d;
  logic [1:0]            rresp_d;
  logic [31:0]           status_w;    // Live status word.

  // Address and data are taken in either order; the response follows both
  // and the pair is released only once the response is accepted, so one
  // write at a time is in flight.
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    ctrl_d    = ctrl_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      bvalid_d = 1'b1;
      bresp_d  = addr_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      // Only the control word is writable; other mapped words ignore writes.
      if (aw_addr_q == `OFF_CTRL) begin
        if (w_strb_q[0]) ctrl_d[7:0]  = w_data_q[7:0];
        if (w_strb_q[1]) ctrl_d[15:8] = w_data_q[15:8];
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d  = 1'b0;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
    end
  end

  // Status word: power save, lock and wake-up window state.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`STAT_PSAVE_POS]  = power_saving;
    status_w[`STAT_LOCK_POS]   = lock_detect;
    status_w[`STAT_SETTLE_POS] = (settle_q != '0);
  end

  // Reads answer one cycle after the address is taken.
  always_comb begin
    arready_d = ~s_axi_rvalid;
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFF_REF_WORD:  rdata_d = 32'(ref_q);
        `OFF_MAIN_WORD: rdata_d = 32'(main_q);
        `OFF_STATUS:    rdata_d = status_w;
        `OFF_CTRL:      rdata_d = 32'(ctrl_q);
        default:        rdata_d = 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  // Bus registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= '0;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      ctrl_q        <= `CTRL_RESET;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      aw_have_q     <= aw_have_d;
      aw_addr_q     <= aw_addr_d;
      w_have_q      <= w_have_d;
      w_data_q      <= w_data_d;
      w_strb_q      <= w_strb_d;
      s_axi_awready <= ~aw_have_d;
      s_axi_wready  <= ~w_have_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      ctrl_q        <= ctrl_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end

endmodule : pll_synth_serial_control

// ==== pll_synth_properties.sv ====
// Concurrent checks on the ports of the synthesizer control block.
`timescale 1ns/1ns
module pll_synth_checker (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      load_strobe,
  input wire logic                      power_save_pin,
  input wire logic                      pump_output_enable_pin,
  input wire logic                      ref_div_pulse,
  input wire logic                      cmp_div_pulse,
  input wire logic                      s_axi_arready,
  input wire pll_synth_pkg::ref_word_s  ref_setting,
  input wire pll_synth_pkg::main_word_s main_setting,
  input wire logic                      pump_out,
  input wire logic                      pump_oe,
  input wire logic                      phase_ref_out,
  input wire logic                      phase_cmp_out,
  input wire logic                      phase_cmp_oe,
  input wire logic                      lock_detect
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Polarity of the latched reference word.
  wire pol = ref_setting.phase_polarity_bit;
  // No pulses and no power save: the flags hold their value.
  sequence calm_s;
    power_save_pin && !ref_div_pulse && !cmp_div_pulse;
  endsequence
  // A lone reference pulse while no down error is showing.
  sequence up_s;
    power_save_pin && ref_div_pulse && !cmp_div_pulse && !(pol ? phase_ref_out : phase_cmp_oe);
  endsequence
  up_dir_a: assert property (calm_s ##1 up_s |-> ##2
    (phase_ref_out == !pol && phase_cmp_oe == pol && !lock_detect)) else $error("up dir");
  pump_en_a: assert property (!pump_output_enable_pin [*5] |-> !pump_oe)
    else $error("pump enable");
  psave_pump_a: assert property (!power_save_pin [*5] |-> !pump_oe)
    else $error("psave pump");
  psave_lock_a: assert property (!power_save_pin [*5] |-> lock_detect)
    else $error("psave lock");
  latch_hold_a: assert property ($stable(load_strobe) [*8] |->
    $stable(ref_setting) && $stable(main_setting)) else $error("latch hold");
  cmp_low_a: assert property (!phase_cmp_out) else $error("cmp level");
  phase_rel_a: assert property (pump_oe |->
    phase_ref_out != pump_out && phase_cmp_oe == pump_out) else $error("phase rel");
  err_lock_a: assert property ((phase_ref_out || phase_cmp_oe) |->
    !lock_detect && !(phase_ref_out && phase_cmp_oe)) else $error("err lock");
  ready_rst_a: assert property ($rose(aresetn) |=> s_axi_arready) else $error("ready");
endmodule : pll_synth_checker

bind pll_synth_serial_control pll_synth_checker u_chk (.*);

// ==== serial_host_model.sv ====
// Host model that shifts words into the three-wire link.
`timescale 1ns/1ns
module serial_host_model (
  output logic ser_data_pin,
  output logic ser_clk_pin,
  output logic load_strobe
);
  // The link clock rests low between frames.
  initial begin
    ser_data_pin = 1'b0;
    ser_clk_pin  = 1'b0;
    load_strobe  = 1'b1;
  end

  // Sends one word with data set half a period before each rise.
  task automatic send_word(input logic [18:0] w);
    // Start off the bench clock's edges so every pin change falls between samples.
    #10;
    load_strobe = 1'b0;
    for (int i = 18; i >= 0; i--) begin
      ser_data_pin = w[i];
      #200 ser_clk_pin = 1'b1;
      #200 ser_clk_pin = 1'b0;
    end
    // Invert the stale bit so a late sample cannot match by luck.
    ser_data_pin = ~w[0];
    #200 load_strobe = 1'b1;
    #400;
  endtask : send_word
endmodule : serial_host_model

// ==== tb.sv ====
// Self-checking bench for the synthesizer control block.
`timescale 1ns/1ns
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, power_save_pin = 1'b0, pump_output_enable_pin = 1'b1;
  logic ref_div_pulse = 1'b0, cmp_div_pulse = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic ser_data_pin, ser_clk_pin, load_strobe, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pump_out, pump_oe, phase_ref_out, phase_cmp_out;
  logic phase_cmp_oe, monitor_out, lock_detect, mon;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pll_synth_pkg::ref_word_s  ref_setting, w_ref;
  pll_synth_pkg::main_word_s main_setting, w_main;
  int error_cnt = 0, total_checks = 0, cyc = 0;

  pll_synth_serial_control u_dut (.*);
  serial_host_model u_host (.*);

  always #25 aclk = ~aclk;

  // Cuts a hang short; the full run needs well under this many cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Write cycle: both channels offered together, each dropped once taken.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : axi_rd

  // Shifts a word in and waits for the latch to settle.
  task automatic load_ref(input logic [3:0] cfg, input logic [13:0] r);
    w_ref = {cfg, r, 1'b1};
    u_host.send_word(w_ref);
    repeat (8) @(posedge aclk);
    chk(ref_setting, w_ref);
    chk(main_setting, w_main);
  endtask : load_ref

  task automatic load_main(input logic [10:0] n, input logic [6:0] a);
    w_main = {n, a, 1'b0};
    u_host.send_word(w_main);
    repeat (8) @(posedge aclk);
    chk(main_setting, w_main);
    chk(ref_setting, w_ref);
  endtask : load_main

  // One-cycle divider pulses; mon records any monitor activity.
  task automatic pulse(input logic r, input logic c);
    @(posedge aclk);
    ref_div_pulse <= r;
    cmp_div_pulse <= c;
    @(posedge aclk);
    ref_div_pulse <= 1'b0;
    cmp_div_pulse <= 1'b0;
    #1 mon = monitor_out;
    repeat (3) begin
      @(posedge aclk);
      #1 mon = mon | monitor_out;
    end
  endtask : pulse

  task automatic t_regs;
    axi_rd(4'h0, 32'h0000_0006, 2'h0);
    axi_rd(4'h4, 32'h0000_0300, 2'h0);
    axi_rd(4'hC, 32'h0000_0040, 2'h0);
    axi_rd(4'h2, 32'h0000_0000, 2'h2);
    axi_wr(4'h6, 32'h0000_0001, 2'h2);
    axi_wr(4'h0, 32'h0000_0000, 2'h0);
    axi_rd(4'h0, 32'h0000_0006, 2'h0);
    axi_wr(4'hC, 32'hABCD_0020, 2'h0);
    axi_rd(4'hC, 32'h0000_0020, 2'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_serial;
    load_ref(4'b1011, 14'h3FFF);
    load_main(11'h7FF, 7'h7F);
    load_ref(4'b0100, 14'h0003);
    load_main(11'h003, 7'h00);
    axi_rd(4'h0, {13'h0000, w_ref}, 2'h0);
    $display("test serial done");
  endtask : t_serial

  task automatic t_phase(input logic p);
    load_ref({2'b01, p, 1'b0}, 14'h0010);
    pulse(1'b1, 1'b0);
    chk({pump_oe, pump_out, phase_ref_out, phase_cmp_oe, lock_detect, mon}, {1'b1, p, !p, p, 1'b0, p});
    pulse(1'b1, 1'b1);
    chk({pump_oe, phase_ref_out, phase_cmp_oe, lock_detect}, 4'b0001);
    pulse(1'b0, 1'b1);
    chk({pump_oe, pump_out, phase_ref_out, phase_cmp_oe, lock_detect, mon}, {1'b1, !p, p, !p, 1'b0, !p});
    pulse(1'b1, 1'b1);
    $display("test phase done");
  endtask : t_phase

  task automatic t_gate;
    load_ref(4'b0010, 14'h0010);
    chk(monitor_out, lock_detect);
    pump_output_enable_pin <= 1'b0;
    pulse(1'b1, 1'b0);
    chk({pump_oe, phase_cmp_oe, monitor_out}, 3'b010);
    pump_output_enable_pin <= 1'b1;
    power_save_pin <= 1'b0;
    repeat (5) @(posedge aclk);
    #1 chk({pump_oe, lock_detect, phase_cmp_oe}, 3'b010);
    axi_rd(4'h8, 32'h0000_0003, 2'h0);
    chk(ref_setting, w_ref);
    power_save_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(4'h8, 32'h0000_0006, 2'h0);
    pulse(1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    #1 chk({pump_oe, phase_cmp_oe}, 2'b01);
    pulse(1'b1, 1'b1);
    repeat (40) @(posedge aclk);
    pulse(1'b1, 1'b0);
    repeat (3) @(posedge aclk);
    #1 chk({pump_oe, pump_out}, 2'b11);
    pulse(1'b1, 1'b1);
    $display("test gate done");
  endtask : t_gate

  initial begin
    w_main = 19'h0_0300;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Power save stays low well past 1 us before release.
    repeat (24) @(posedge aclk);
    power_save_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    t_regs();
    t_serial();
    t_phase(1'b1);
    t_phase(1'b0);
    t_gate();
    stop_test();
  end
endmodule : tb
